// file: rtl/ces_arbiter.sv
// priority arbiter over the 43 maskable sources
// assumes request levels stay asserted until serviced
`timescale 1ns/1ps
`include "ces_map.svh"
module ces_arbiter (
  input wire logic [`CES_NUM_SRC-1:0] i_req,
  input wire logic [`CES_NUM_GRP*3-1:0] i_grp_level,
  input wire logic [2:0] i_mask_level,
  output logic o_valid,
  output logic [5:0] o_src,
  output logic [2:0] o_level
);
  logic [2:0] lvl [`CES_NUM_SRC];
  logic [`CES_NUM_SRC-1:0] elig;
  genvar g;
  generate
    for (g = 0; g < `CES_NUM_SRC; g++) begin : g_src
      localparam int GRP = (g < `CES_FIRST_PINS) ? 0 : (g < `CES_FIRST_TIMER) ? 1 :
        (g < `CES_FIRST_SER1) ? 2 : (g < `CES_FIRST_SER2) ? 3 :
        (g < `CES_IDX_ADC) ? 4 : (g < `CES_IDX_WDT) ? 5 : 6;
      assign lvl[g] = i_grp_level[GRP*3 +: 3];
      assign elig[g] = i_req[g] && (lvl[g] > i_mask_level);
    end
  endgenerate
  // highest level wins, lowest index breaks ties
  always_comb begin
    o_valid = 1'b0;
    o_src = 6'h00;
    o_level = 3'h0;
    for (int i = `CES_NUM_SRC - 1; i >= 0; i--) begin
      if (elig[i] && (!o_valid || lvl[i] >= o_level)) begin
        o_valid = 1'b1;
        o_src = 6'(i);
        o_level = lvl[i];
      end
    end
  end
endmodule

// file: rtl/ces_defer.sv
// tracks the one-instruction window in which exceptions are held off
// assumes completion and disabling flags are single-cycle pulses from the core
`timescale 1ns/1ps
module ces_defer (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_insn_done,
  input wire logic i_insn_disabling,
  input wire logic i_xfer_end,
  output logic o_accept_ok,
  output logic o_defer
);
  logic defer_q;
  // reset, a transfer end or a disabling run each hold off until a plain insn ends
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      defer_q <= 1'b1;
    end else if (i_xfer_end || (i_insn_done && i_insn_disabling)) begin
      defer_q <= 1'b1;
    end else if (i_insn_done) begin
      defer_q <= 1'b0;
    end
  end
  assign o_accept_ok = i_insn_done && !i_insn_disabling;
  assign o_defer = defer_q;
endmodule

// file: rtl/ces_map.svh
// register map, field positions, vectors and fixed counts of the exception sequencer
// assumes a 32-bit AHB-Lite slave with word-aligned registers
`ifndef CES_MAP_SVH
`define CES_MAP_SVH
`define CES_OFF_PRIO 8'h00
`define CES_OFF_TE_LO 8'h04
`define CES_OFF_TE_HI 8'h08
`define CES_OFF_STATUS 8'h0c
`define CES_OFF_CTRL 8'h10
`define CES_OFF_EXC 8'h14
`define CES_NUM_SRC 43
`define CES_NUM_PERIPH 39
`define CES_NUM_GRP 7
`define CES_FIRST_PINS 1
`define CES_FIRST_TIMER 4
`define CES_FIRST_SER1 33
`define CES_FIRST_SER2 37
`define CES_IDX_ADC 41
`define CES_IDX_WDT 42
`define CES_XFER_CAPABLE 43'h3ff_ffff_ffff
`define CES_TE_HI_W 11
`define CES_SR_T 15
`define CES_SR_I_HI 10
`define CES_SR_I_LO 8
`define CES_SR_RESET 16'h0700
`define CES_SR_MASK 16'h8700
`define CES_NMI_LEVEL 3'h7
`define CES_VEC_ADDRERR 8'h03
`define CES_VEC_INVALID 8'h04
`define CES_VEC_ZERODIV 8'h05
`define CES_VEC_TRAPV 8'h06
`define CES_VEC_TRACE 8'h09
`define CES_VEC_NMI 8'h0b
`define CES_VEC_TRAP_BASE 4'h2
`define CES_VEC_IRQ_BASE 8'h40
`define CES_HTRANS_NONSEQ 2'h2
`define CES_SP_REG 3'h7
`endif

// file: rtl/ces_pkg.sv
// types used by the exception sequencer top module
// no constants here: offsets and counts live in ces_map.svh
package ces_pkg;
  typedef enum logic [3:0] {
    CES_CAUSE_NONE = 4'h0,
    CES_CAUSE_INVALID = 4'h1,
    CES_CAUSE_TRAP = 4'h2,
    CES_CAUSE_ZERODIV = 4'h3,
    CES_CAUSE_ADDRERR = 4'h4,
    CES_CAUSE_NMI = 4'h5,
    CES_CAUSE_TRACE = 4'h6,
    CES_CAUSE_IRQ = 4'h7
  } ces_cause_type;
  typedef enum logic [1:0] {
    CES_ST_IDLE = 2'h0,
    CES_ST_SEQ = 2'h1,
    CES_ST_XFER = 2'h2
  } ces_state_type;
endpackage

// file: rtl/ces_top.sv
// exception sequencer: picks the exception taken at each instruction boundary
// assumes one AHB-Lite master and a core that reports completion pulses
`timescale 1ns/1ps
`include "ces_map.svh"
module ces_top (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_nmi,
  input wire logic i_flash_busy,
  input wire logic [3:0] i_ext_request_pin_n,
  input wire logic [`CES_NUM_PERIPH-1:0] i_periph_req,
  input wire logic i_insn_done,
  input wire logic i_insn_disabling,
  input wire logic [23:0] i_insn_pc,
  input wire logic [23:0] i_next_pc,
  input wire logic i_invalid_insn,
  input wire logic i_unconditional_trap,
  input wire logic [3:0] i_trap_vector,
  input wire logic i_overflow_trap,
  input wire logic i_ccr_overflow,
  input wire logic i_unsigned_divide_zero,
  input wire logic i_stack_access,
  input wire logic i_sp_lsb,
  input wire logic i_seq_done,
  input wire logic i_ea_autoinc,
  input wire logic [2:0] i_ea_reg,
  input wire logic i_size_byte,
  output logic o_access_byte,
  output logic o_exc_req,
  output logic [3:0] o_exc_cause,
  output logic [15:0] o_exc_vec_addr,
  output logic [23:0] o_saved_pc,
  output logic o_transfer_start,
  output logic [5:0] o_transfer_src,
  input wire logic i_transfer_done,
  output logic o_cpu_halt,
  output logic o_trace_bit,
  output logic [2:0] o_mask_level
);
  ces_pkg::ces_state_type state_q;
  ces_pkg::ces_cause_type cause_d;
  ces_pkg::ces_cause_type cause_q;
  logic [`CES_NUM_GRP*3-1:0] prio_q;
  logic [`CES_NUM_SRC-1:0] te_q;
  logic [15:0] sr_q;
  logic max_mode_q;
  logic nmi_q;
  logic nmi_pend_q;
  logic addr_err_q;
  logic [23:0] pc_q;
  logic [15:0] vec_q;
  logic xfer_start_q;
  logic [5:0] xfer_src_q;
  logic [31:0] rdata_q;
  logic wr_q;
  logic [7:0] waddr_q;
  logic [7:0] vec_num;
  logic [`CES_NUM_SRC-1:0] irq_req;
  logic arb_valid;
  logic [5:0] arb_src;
  logic [2:0] arb_level;
  logic accept_ok;
  logic defer;
  logic take;
  logic trap_now;
  logic to_xfer;
  logic [`CES_NUM_SRC-1:0] xfer_capable;
  logic xfer_end;
  logic addr_phase;
  logic [31:0] rd_val;

  // pins are active low; peripherals follow pin sources
  assign irq_req = {i_periph_req, ~i_ext_request_pin_n};

  ces_arbiter u_arb (
    .i_req(irq_req),
    .i_grp_level(prio_q),
    .i_mask_level(sr_q[`CES_SR_I_HI:`CES_SR_I_LO]),
    .o_valid(arb_valid),
    .o_src(arb_src),
    .o_level(arb_level)
  );

  assign xfer_end = (state_q == ces_pkg::CES_ST_XFER) && i_transfer_done;

  ces_defer u_defer (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_insn_done(i_insn_done && (state_q == ces_pkg::CES_ST_IDLE)),
    .i_insn_disabling(i_insn_disabling),
    .i_xfer_end(xfer_end),
    .o_accept_ok(accept_ok),
    .o_defer(defer)
  );

  // nmi edge capture; flash work blocks new edges
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= i_nmi;
    end
  end

  // odd stack pointer on a stack access
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      addr_err_q <= 1'b0;
    end else if (i_stack_access && i_sp_lsb) begin
      addr_err_q <= 1'b1;
    end else if (take && cause_d == ces_pkg::CES_CAUSE_ADDRERR) begin
      addr_err_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      nmi_pend_q <= 1'b0;
    end else if (i_nmi && !nmi_q && !i_flash_busy) begin
      nmi_pend_q <= 1'b1;
    end else if (take && cause_d == ces_pkg::CES_CAUSE_NMI) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // boundary decision: instruction faults first, then deferrable ones
  assign trap_now = i_unconditional_trap || (i_overflow_trap && i_ccr_overflow);
  always_comb begin
    cause_d = ces_pkg::CES_CAUSE_NONE;
    if (i_invalid_insn) begin
      cause_d = ces_pkg::CES_CAUSE_INVALID;
    end else if (trap_now) begin
      cause_d = ces_pkg::CES_CAUSE_TRAP;
    end else if (i_unsigned_divide_zero) begin
      cause_d = ces_pkg::CES_CAUSE_ZERODIV;
    end else if (!accept_ok) begin
      cause_d = ces_pkg::CES_CAUSE_NONE;
    end else if (addr_err_q) begin
      cause_d = ces_pkg::CES_CAUSE_ADDRERR;
    end else if (nmi_pend_q) begin
      cause_d = ces_pkg::CES_CAUSE_NMI;
    end else if (sr_q[`CES_SR_T]) begin
      cause_d = ces_pkg::CES_CAUSE_TRACE;
    end else if (arb_valid) begin
      cause_d = ces_pkg::CES_CAUSE_IRQ;
    end
  end

  assign take = i_insn_done && (state_q == ces_pkg::CES_ST_IDLE) &&
    (cause_d != ces_pkg::CES_CAUSE_NONE);
  // sources that may start the engine; the watchdog never does
  assign xfer_capable = `CES_XFER_CAPABLE;
  assign to_xfer = (cause_d == ces_pkg::CES_CAUSE_IRQ) && te_q[arb_src] &&
    xfer_capable[arb_src];

  always_comb begin
    unique case (cause_d)
      ces_pkg::CES_CAUSE_INVALID: vec_num = `CES_VEC_INVALID;
      ces_pkg::CES_CAUSE_TRAP: vec_num = i_unconditional_trap ?
        {`CES_VEC_TRAP_BASE, i_trap_vector} : `CES_VEC_TRAPV;
      ces_pkg::CES_CAUSE_ZERODIV: vec_num = `CES_VEC_ZERODIV;
      ces_pkg::CES_CAUSE_ADDRERR: vec_num = `CES_VEC_ADDRERR;
      ces_pkg::CES_CAUSE_NMI: vec_num = `CES_VEC_NMI;
      ces_pkg::CES_CAUSE_TRACE: vec_num = `CES_VEC_TRACE;
      ces_pkg::CES_CAUSE_IRQ: vec_num = `CES_VEC_IRQ_BASE + {2'h0, arb_src};
      default: vec_num = 8'h00;
    endcase
  end

  // sequencer state
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ces_pkg::CES_ST_IDLE;
    end else begin
      unique case (state_q)
        ces_pkg::CES_ST_IDLE: begin
          if (take) begin
            state_q <= to_xfer ? ces_pkg::CES_ST_XFER : ces_pkg::CES_ST_SEQ;
          end
        end
        ces_pkg::CES_ST_SEQ: begin
          if (i_seq_done) begin
            state_q <= ces_pkg::CES_ST_IDLE;
          end
        end
        ces_pkg::CES_ST_XFER: begin
          if (i_transfer_done) begin
            state_q <= ces_pkg::CES_ST_IDLE;
          end
        end
        default: state_q <= ces_pkg::CES_ST_IDLE;
      endcase
    end
  end

  // exception answer held for the core until its sequence ends
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cause_q <= ces_pkg::CES_CAUSE_NONE;
      pc_q <= 24'h00_0000;
      vec_q <= 16'h0000;
    end else if (take && !to_xfer) begin
      cause_q <= cause_d;
      pc_q <= (cause_d == ces_pkg::CES_CAUSE_INVALID) ? i_insn_pc : i_next_pc;
      vec_q <= max_mode_q ? {6'h00, vec_num, 2'h0} : {7'h00, vec_num, 1'h0};
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      xfer_start_q <= 1'b0;
      xfer_src_q <= 6'h00;
    end else begin
      xfer_start_q <= take && to_xfer;
      if (take && to_xfer) begin
        xfer_src_q <= arb_src;
      end
    end
  end

  // bus address phase capture
  assign addr_phase = i_hsel && i_hready && (i_htrans == `CES_HTRANS_NONSEQ);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
    end else begin
      wr_q <= addr_phase && i_hwrite;
      if (addr_phase) begin
        waddr_q <= {i_haddr[7:2], 2'h0};
      end
    end
  end

  // software configuration
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      prio_q <= '0;
      te_q <= '0;
      max_mode_q <= 1'b0;
    end else if (wr_q) begin
      if (waddr_q == `CES_OFF_PRIO) begin
        for (int g = 0; g < `CES_NUM_GRP; g++) begin
          prio_q[g*3 +: 3] <= i_hwdata[g*4 +: 3];
        end
      end
      if (waddr_q == `CES_OFF_TE_LO) begin
        te_q[31:0] <= i_hwdata;
      end
      if (waddr_q == `CES_OFF_TE_HI) begin
        te_q[`CES_NUM_SRC-1:32] <= i_hwdata[`CES_TE_HI_W-1:0];
      end
      if (waddr_q == `CES_OFF_CTRL) begin
        max_mode_q <= i_hwdata[0];
      end
    end
  end

  // status register: exception entry overrides a software write
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sr_q <= `CES_SR_RESET;
    end else if (take && !to_xfer) begin
      if (cause_d == ces_pkg::CES_CAUSE_NMI) begin
        sr_q[`CES_SR_I_HI:`CES_SR_I_LO] <= `CES_NMI_LEVEL;
      end else if (cause_d == ces_pkg::CES_CAUSE_IRQ) begin
        sr_q[`CES_SR_I_HI:`CES_SR_I_LO] <= arb_level;
      end else begin
        sr_q[`CES_SR_T] <= 1'b0;
      end
    end else if (wr_q && waddr_q == `CES_OFF_STATUS) begin
      sr_q <= i_hwdata[15:0] & `CES_SR_MASK;
    end
  end

  // read mux sampled in the address phase
  always_comb begin
    unique case ({i_haddr[7:2], 2'h0})
      `CES_OFF_PRIO: begin
        rd_val = 32'h0000_0000;
        for (int g = 0; g < `CES_NUM_GRP; g++) begin
          rd_val[g*4 +: 3] = prio_q[g*3 +: 3];
        end
      end
      `CES_OFF_TE_LO: rd_val = te_q[31:0];
      `CES_OFF_TE_HI: rd_val = {21'h00_0000, te_q[`CES_NUM_SRC-1:32]};
      `CES_OFF_STATUS: rd_val = {16'h0000, sr_q};
      `CES_OFF_CTRL: rd_val = {31'h0000_0000, max_mode_q};
      `CES_OFF_EXC: rd_val = {pc_q[15:0], 4'h0, addr_err_q, nmi_pend_q, defer,
        1'b0, 2'h0, state_q, cause_q};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_phase && !i_hwrite) begin
      rdata_q <= rd_val;
    end
  end

  // pointer auto-modify through the stack pointer forces word size
  assign o_access_byte = i_size_byte && !(i_ea_autoinc && i_ea_reg == `CES_SP_REG);

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_q;
  assign o_exc_req = (state_q == ces_pkg::CES_ST_SEQ);
  assign o_exc_cause = cause_q;
  assign o_exc_vec_addr = vec_q;
  assign o_saved_pc = pc_q;
  assign o_transfer_start = xfer_start_q;
  assign o_transfer_src = xfer_src_q;
  assign o_cpu_halt = (state_q == ces_pkg::CES_ST_XFER);
  assign o_trace_bit = sr_q[`CES_SR_T];
  assign o_mask_level = sr_q[`CES_SR_I_HI:`CES_SR_I_LO];
endmodule

// file: testbench/ces_sva.sv
// checker: assertions on the exception sequencer top ports
// assumes one clock domain, async active-high reset
`timescale 1ns/1ps
module ces_sva (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_insn_done,
  input wire logic i_insn_disabling,
  input wire logic [23:0] i_insn_pc,
  input wire logic [23:0] i_next_pc,
  input wire logic i_invalid_insn,
  input wire logic i_unconditional_trap,
  input wire logic i_overflow_trap,
  input wire logic i_ccr_overflow,
  input wire logic i_unsigned_divide_zero,
  input wire logic i_ea_autoinc,
  input wire logic [2:0] i_ea_reg,
  input wire logic i_size_byte,
  input wire logic o_access_byte,
  input wire logic o_exc_req,
  input wire logic [3:0] o_exc_cause,
  input wire logic [23:0] o_saved_pc,
  input wire logic o_transfer_start,
  input wire logic o_cpu_halt,
  input wire logic o_trace_bit,
  input wire logic [2:0] o_mask_level
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  logic seen_q;
  wire idle = i_insn_done && !o_exc_req && !o_cpu_halt;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      seen_q <= 1'b0;
    end else if (i_insn_done) begin
      seen_q <= 1'b1;
    end
  end
  property p_first;
    !seen_q |-> !o_exc_req && !o_transfer_start;
  endproperty
  a_first: assert property (p_first) else $error("early exception");
  property p_inv;
    idle && i_invalid_insn |=> o_exc_req && o_exc_cause == 4'h1 &&
      o_saved_pc == $past(i_insn_pc);
  endproperty
  a_inv: assert property (p_inv) else $error("invalid entry");
  property p_trap;
    idle && i_unconditional_trap && !i_invalid_insn |=>
      o_exc_cause == 4'h2 && o_saved_pc == $past(i_next_pc);
  endproperty
  a_trap: assert property (p_trap) else $error("trap entry");
  property p_ovf;
    idle && i_overflow_trap && !i_ccr_overflow |=>
      !(o_exc_req && o_exc_cause == 4'h2) || $past(i_unconditional_trap);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow trap");
  property p_zdiv;
    idle && i_unsigned_divide_zero && !i_invalid_insn && !i_unconditional_trap &&
      !(i_overflow_trap && i_ccr_overflow) |=> o_exc_req && o_exc_cause == 4'h3;
  endproperty
  a_zdiv: assert property (p_zdiv) else $error("zero divide");
  property p_clr;
    $rose(o_exc_req) && o_exc_cause inside {4'h1, 4'h2, 4'h3} |->
      !o_trace_bit && $stable(o_mask_level);
  endproperty
  a_clr: assert property (p_clr) else $error("status on entry");
  property p_defer;
    idle && i_insn_disabling |=> !o_transfer_start &&
      !(o_exc_req && o_exc_cause inside {4'h4, 4'h5, 4'h6, 4'h7});
  endproperty
  a_defer: assert property (p_defer) else $error("not deferred");
  property p_word;
    i_ea_autoinc && i_ea_reg == 3'h7 |-> !o_access_byte;
  endproperty
  a_word: assert property (p_word) else $error("stack byte access");
  property p_byte;
    i_ea_autoinc && i_ea_reg != 3'h7 && i_size_byte |-> o_access_byte;
  endproperty
  a_byte: assert property (p_byte) else $error("byte size lost");
  cover property ($rose(o_exc_req) && o_exc_cause == 4'h7);
  cover property (o_transfer_start);
  cover property ($fell(o_cpu_halt));
endmodule
bind ces_top ces_sva i_chk (.*);

// file: testbench/ces_xfer_model.sv
// transfer engine model: runs i_delay+1 cycles per start
// assumes start is a one-cycle pulse
`timescale 1ns/1ps
module ces_xfer_model (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [3:0] i_delay,
  output logic o_done
);
  logic busy_q;
  logic [3:0] cnt_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        busy_q <= 1'b1;
        cnt_q <= i_delay;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        o_done <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// file: testbench/cpu_exception_sequencing_bench.sv
// bench: bus and instruction-boundary tasks, expected values
// assumes hreadyout feeds hready, one engine model
`timescale 1ns/1ps
`include "ces_map.svh"
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module cpu_exception_sequencing_bench;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, done = 0, nmi = 0, fb = 0;
  logic stk = 0, lsb = 0, sdn = 0, ai = 0, sb = 0, mx = 0, hro, xd, start, halt;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, q;
  logic [5:0] fl = 0;
  logic [3:0] pins = 4'hf, tv = 0, dly = 0;
  logic [2:0] ea = 0;
  logic [23:0] ipc = 24'h100;
  logic [`CES_NUM_PERIPH-1:0] per = 0;
  int err_count = 0, n_tests = 0;
  ces_top i_ces_top (.i_clk_sys(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hro), .o_hreadyout(hro), .o_hresp(), .o_hrdata(q), .i_nmi(nmi),
    .i_flash_busy(fb), .i_ext_request_pin_n(pins), .i_periph_req(per),
    .i_insn_done(done), .i_insn_disabling(fl[0]), .i_insn_pc(ipc),
    .i_next_pc(ipc + 24'h2), .i_invalid_insn(fl[1]), .i_unconditional_trap(fl[2]),
    .i_trap_vector(tv), .i_overflow_trap(fl[3]), .i_ccr_overflow(fl[4]),
    .i_unsigned_divide_zero(fl[5]), .i_stack_access(stk), .i_sp_lsb(lsb),
    .i_seq_done(sdn), .i_ea_autoinc(ai), .i_ea_reg(ea), .i_size_byte(sb),
    .o_access_byte(), .o_exc_req(), .o_exc_cause(), .o_exc_vec_addr(),
    .o_saved_pc(), .o_transfer_start(start), .o_transfer_src(),
    .i_transfer_done(xd), .o_cpu_halt(halt), .o_trace_bit(), .o_mask_level());
  ces_xfer_model i_ces_xfer_model (.i_clk_sys(clk), .i_rst(rst), .i_start(start),
    .i_delay(dly), .o_done(xd));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hro !== 1'b1) @(posedge clk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hro !== 1'b1) @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("rdata", e, q)
  endtask
  task automatic pulse_nmi();
    @(posedge clk);
    nmi <= 1;
    @(posedge clk);
    nmi <= 0;
  endtask
  task automatic st(input logic [5:0] f, input logic [3:0] c, input logic [7:0] v);
    @(posedge clk);
    done <= 1;
    fl <= f;
    ipc <= ipc + 24'h2;
    @(posedge clk);
    done <= 0;
    fl <= 6'h0;
    #1;
    `CHK("exc_req", (c != 4'h0), i_ces_top.o_exc_req)
    if (c != 4'h0) begin
      `CHK("cause", c, i_ces_top.o_exc_cause)
      `CHK("vector", mx ? {6'h0, v, 2'h0} : {7'h0, v, 1'b0}, i_ces_top.o_exc_vec_addr)
      if (c != 4'h4) `CHK("pc", (c == 4'h1) ? ipc : ipc + 24'h2, i_ces_top.o_saved_pc)
      @(posedge clk);
      sdn <= 1;
      @(posedge clk);
      sdn <= 0;
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    rd(`CES_OFF_STATUS, 32'h0700);
    rd(32'h40, 32'h0);
    pulse_nmi();
    repeat (3) @(posedge clk);
    `CHK("early", 1'b0, i_ces_top.o_exc_req)
    st(6'h1, 4'h0, 8'd0);
    st(6'h0, 4'h5, 8'd11);
    fb <= 1;
    pulse_nmi();
    st(6'h0, 4'h0, 8'd0);
    fb <= 0;
    bus(1'b1, `CES_OFF_STATUS, 32'h8300);
    st(6'h2, 4'h1, 8'd4);
    `CHK("trace", 1'b0, i_ces_top.o_trace_bit)
    `CHK("mask", 3'h3, i_ces_top.o_mask_level)
    bus(1'b1, `CES_OFF_STATUS, 32'h8300);
    st(6'h0, 4'h6, 8'd9);
    for (int n = 0; n < 16; n++) begin
      tv <= n[3:0];
      st(6'h4, 4'h2, 8'(32 + n));
    end
    bus(1'b1, `CES_OFF_CTRL, 32'h1);
    rd(`CES_OFF_CTRL, 32'h1);
    mx = 1'b1;
    st(6'h4, 4'h2, 8'd47);
    mx = 1'b0;
    bus(1'b1, `CES_OFF_CTRL, 32'h0);
    st(6'h8, 4'h0, 8'd0);
    st(6'h18, 4'h2, 8'd6);
    st(6'h20, 4'h3, 8'd5);
    bus(1'b1, `CES_OFF_PRIO, 32'h0600_0305);
    bus(1'b1, `CES_OFF_STATUS, 32'h0400);
    pins <= 4'he;
    per <= 1;
    st(6'h4, 4'h2, 8'd47);
    st(6'h0, 4'h7, 8'd64);
    `CHK("mask", 3'h5, i_ces_top.o_mask_level)
    pins <= 4'hf;
    st(6'h0, 4'h0, 8'd0);
    bus(1'b1, `CES_OFF_PRIO, 32'h0600_0375);
    pins <= 4'hb;
    st(6'h0, 4'h7, 8'd66);
    pins <= 4'hf;
    bus(1'b1, `CES_OFF_STATUS, 32'h0);
    st(6'h1, 4'h0, 8'd0);
    st(6'h1, 4'h0, 8'd0);
    st(6'h0, 4'h7, 8'd68);
    per <= 0;
    bus(1'b1, `CES_OFF_TE_HI, 32'h400);
    bus(1'b1, `CES_OFF_TE_LO, 32'h20);
    bus(1'b1, `CES_OFF_STATUS, 32'h0);
    per[38] <= 1;
    st(6'h0, 4'h7, 8'd106);
    per <= 0;
    bus(1'b1, `CES_OFF_STATUS, 32'h0);
    for (int k = 0; k < 2; k++) begin
      per[1] <= 1;
      dly <= (k == 1) ? 4'h8 : 4'h0;
      st(6'h0, 4'h0, 8'd0);
      `CHK("start", 1'b1, start)
      `CHK("src", 6'd5, i_ces_top.o_transfer_src)
      `CHK("halt", 1'b1, halt)
      per <= 0;
      if (k == 1) pulse_nmi();
      `CHK("nmi_held", 1'b0, i_ces_top.o_exc_req)
      while (halt === 1'b1) @(posedge clk);
      if (k == 1) st(6'h0, 4'h5, 8'd11);
    end
    st(6'h0, 4'h0, 8'd0);
    @(posedge clk);
    stk <= 1;
    lsb <= 1;
    @(posedge clk);
    stk <= 0;
    st(6'h0, 4'h4, 8'd3);
    ai <= 1;
    sb <= 1;
    for (int r = 0; r < 8; r++) begin
      @(posedge clk);
      ea <= r[2:0];
      @(posedge clk);
      `CHK("byte", (r != 7), i_ces_top.o_access_byte)
    end
    results();
  end
endmodule
